// ==== common/cmp_defs.vh ====
// Register map, field positions and reset values of the comparator regs
`ifndef CMP_DEFS_VH
`define CMP_DEFS_VH

// Register indices as printed; byte address is four times the index
`define CMP_IDX_CTRL 8'h9b
`define CMP_IDX_MODE 8'h9d
`define CMP_IDX_PAGE 8'h3f
`define CMP_ADDR_W 12
`define CMP_ADDR_CTRL 12'h26c
`define CMP_ADDR_MODE 12'h274
`define CMP_ADDR_PAGE 12'h0fc

// Register pages at which the comparator registers are visible
`define CMP_PAGE_A 8'h00
`define CMP_PAGE_B 8'h10

// Control register fields
`define CMP_CTRL_ON 7
`define CMP_CTRL_RESULT 6
`define CMP_CTRL_RISE 5
`define CMP_CTRL_FALL 4
`define CMP_CTRL_PHYS_HI 3
`define CMP_CTRL_PHYS_LO 2
`define CMP_CTRL_NHYS_HI 1
`define CMP_CTRL_NHYS_LO 0

// Mode register fields
`define CMP_MODE_SAMPLED 7
`define CMP_MODE_INVERT 6
`define CMP_MODE_RISE_EN 5
`define CMP_MODE_FALL_EN 4
`define CMP_MODE_ROUTE_HI 3
`define CMP_MODE_ROUTE_LO 2
`define CMP_MODE_RESP_HI 1
`define CMP_MODE_RESP_LO 0

// Reset values
`define CMP_HYST_RST 2'h0
`define CMP_ROUTE_RST 2'h0
`define CMP_RESP_RST 2'h2
`define CMP_PAGE_RST 8'h00

`endif

// ==== core/comparator_ctrl_status_regs.v ====
// Control and status registers of one analog comparator, APB slave
`timescale 1ns/1ps
`include "cmp_defs.vh"
module comparator_ctrl_status_regs (
  input wire i_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [31:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [3:0] i_pstrb,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  // Comparator core side
  input wire i_plus_gt_minus,
  input wire i_counter_overflow,
  output wire o_comparator_on,
  output wire [1:0] o_pos_hyst_sel,
  output wire [1:0] o_neg_hyst_sel,
  output wire [1:0] o_input_routing_sel,
  output wire [1:0] o_response_mode_sel,
  output wire o_compare_result,
  output wire o_routed_result,
  output wire o_rise_irq,
  output wire o_fall_irq
);

  // Control register storage
  reg comparator_on_q;
  reg [1:0] pos_hyst_sel_q;
  reg [1:0] neg_hyst_sel_q;
  // Mode register storage
  reg overflow_sampled_result_q;
  reg result_invert_q;
  reg rise_irq_en_q;
  reg fall_irq_en_q;
  reg [1:0] input_routing_sel_q;
  reg [1:0] response_mode_sel_q;
  // Register page select
  reg [7:0] page_q;
  // Result history for edge detection
  reg result_q;
  reg result_prev_q;
  // Flags, index 0 rising and index 1 falling
  wire [1:0] flag_q;
  wire [1:0] flag_set;
  wire [1:0] flag_clr;

  wire compare_result;
  wire access;
  wire setup;
  wire wr_en;
  wire page_ok;
  wire [`CMP_ADDR_W-1:0] addr;
  wire hit_ctrl;
  wire hit_mode;
  wire hit_page;
  wire mapped;
  wire [7:0] ctrl_rd;
  wire [7:0] mode_rd;
  wire wr_ctrl;
  wire wr_mode;
  wire wr_page;

  // Result after inversion, taken at the comparator source
  assign compare_result = i_plus_gt_minus ^ result_invert_q;

  // APB phase decode
  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign addr = i_paddr[`CMP_ADDR_W-1:0];

  // The comparator registers are visible from both register pages
  assign page_ok = (page_q == `CMP_PAGE_A) || (page_q == `CMP_PAGE_B);

  // Address decode; upper address bits must be zero
  assign hit_ctrl = (addr == `CMP_ADDR_CTRL) && page_ok &&
                    (i_paddr[31:`CMP_ADDR_W] == 20'h00000);
  assign hit_mode = (addr == `CMP_ADDR_MODE) && page_ok &&
                    (i_paddr[31:`CMP_ADDR_W] == 20'h00000);
  assign hit_page = (addr == `CMP_ADDR_PAGE) &&
                    (i_paddr[31:`CMP_ADDR_W] == 20'h00000);
  assign mapped = hit_ctrl | hit_mode | hit_page;

  // Zero wait state slave, error on unmapped access
  assign o_pready = 1'b1;
  assign o_pslverr = access & ~mapped;

  // Writes land in the access phase, low byte lane only
  assign wr_en = access & i_pwrite & i_pstrb[0];
  assign wr_ctrl = wr_en & hit_ctrl;
  assign wr_mode = wr_en & hit_mode;
  assign wr_page = wr_en & hit_page;

  // Read views of the two comparator registers
  assign ctrl_rd = {comparator_on_q, result_q, flag_q[0], flag_q[1],
                    pos_hyst_sel_q, neg_hyst_sel_q};
  assign mode_rd = {overflow_sampled_result_q, result_invert_q,
                    rise_irq_en_q, fall_irq_en_q, input_routing_sel_q,
                    response_mode_sel_q};

  // Read data is captured in the setup phase and held into the access
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
    end else if (setup && !i_pwrite) begin
      if (hit_ctrl) begin
        o_prdata <= {24'h000000, ctrl_rd};
      end else if (hit_mode) begin
        o_prdata <= {24'h000000, mode_rd};
      end else if (hit_page) begin
        o_prdata <= {24'h000000, page_q};
      end else begin
        o_prdata <= 32'h00000000;
      end
    end
  end

  // Page select register
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      page_q <= `CMP_PAGE_RST;
    end else if (wr_page) begin
      page_q <= i_pwdata[7:0];
    end
  end

  // Control register writable fields; result bit writes are dropped
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      comparator_on_q <= 1'b0;
      pos_hyst_sel_q <= `CMP_HYST_RST;
      neg_hyst_sel_q <= `CMP_HYST_RST;
    end else if (wr_ctrl) begin
      comparator_on_q <= i_pwdata[`CMP_CTRL_ON];
      pos_hyst_sel_q <=
        i_pwdata[`CMP_CTRL_PHYS_HI:`CMP_CTRL_PHYS_LO];
      neg_hyst_sel_q <=
        i_pwdata[`CMP_CTRL_NHYS_HI:`CMP_CTRL_NHYS_LO];
    end
  end

  // Mode register fields other than the sampled result
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      result_invert_q <= 1'b0;
      rise_irq_en_q <= 1'b0;
      fall_irq_en_q <= 1'b0;
      input_routing_sel_q <= `CMP_ROUTE_RST;
      response_mode_sel_q <= `CMP_RESP_RST;
    end else if (wr_mode) begin
      result_invert_q <= i_pwdata[`CMP_MODE_INVERT];
      rise_irq_en_q <= i_pwdata[`CMP_MODE_RISE_EN];
      fall_irq_en_q <= i_pwdata[`CMP_MODE_FALL_EN];
      input_routing_sel_q <=
        i_pwdata[`CMP_MODE_ROUTE_HI:`CMP_MODE_ROUTE_LO];
      response_mode_sel_q <=
        i_pwdata[`CMP_MODE_RESP_HI:`CMP_MODE_RESP_LO];
    end
  end

  // Result sampled at each overflow; overflow beats a software write
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      overflow_sampled_result_q <= 1'b0;
    end else if (i_counter_overflow) begin
      overflow_sampled_result_q <= result_q;
    end else if (wr_mode) begin
      overflow_sampled_result_q <= i_pwdata[`CMP_MODE_SAMPLED];
    end
  end

  // Live result register and its previous value for edge detection
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      result_q <= 1'b0;
      result_prev_q <= 1'b0;
    end else begin
      result_q <= compare_result;
      result_prev_q <= result_q;
    end
  end

  // Edge events set the flags; writing 0 to a flag bit clears it
  assign flag_set[0] = result_q & ~result_prev_q;
  assign flag_set[1] = ~result_q & result_prev_q;
  assign flag_clr[0] = wr_ctrl & ~i_pwdata[`CMP_CTRL_RISE];
  assign flag_clr[1] = wr_ctrl & ~i_pwdata[`CMP_CTRL_FALL];

  // One sticky flag per edge direction
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_flag
      sticky_flag u_flag (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_set(flag_set[g]),
        .i_clr(flag_clr[g]),
        .o_flag_q(flag_q[g])
      );
    end
  endgenerate

  // Interrupt requests gated by their enable bits
  assign o_rise_irq = flag_q[0] & rise_irq_en_q;
  assign o_fall_irq = flag_q[1] & fall_irq_en_q;

  // Settings out to the comparator core
  assign o_comparator_on = comparator_on_q;
  assign o_pos_hyst_sel = pos_hyst_sel_q;
  assign o_neg_hyst_sel = neg_hyst_sel_q;
  assign o_input_routing_sel = input_routing_sel_q;
  assign o_response_mode_sel = response_mode_sel_q;

  // Result outputs; the routed copy is low while disabled
  assign o_compare_result = result_q;
  assign o_routed_result = result_q & comparator_on_q;

endmodule

// ==== core/sticky_flag.v ====
// Sticky event flag: hardware sets, software clears, set wins
`timescale 1ns/1ps
module sticky_flag (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_set,
  input wire i_clr,
  output reg o_flag_q
);

  // Set has priority over a clear in the same cycle
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_flag_q <= 1'b0;
    end else if (i_set) begin
      o_flag_q <= 1'b1;
    end else if (i_clr) begin
      o_flag_q <= 1'b0;
    end
  end

endmodule

// ==== sim/cmp_regs_checker.sv ====
// Port-level assertions for the comparator register block
`timescale 1ns/1ps
module cmp_regs_checker (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire i_plus_gt_minus,
  input wire o_comparator_on,
  input wire [1:0] o_pos_hyst_sel,
  input wire [1:0] o_neg_hyst_sel,
  input wire o_compare_result,
  input wire o_routed_result,
  input wire o_rise_irq,
  input wire o_fall_irq
);
  // Access phase of a bus write
  wire wr = i_psel & i_penable & i_pwrite;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Result moves only after an input change or a write one or two cycles back
  property p_res; $changed(o_compare_result) |-> $past(wr) || $past(wr, 2)
    || ($past(i_plus_gt_minus) != $past(i_plus_gt_minus, 2)); endproperty
  a_res: assert property (p_res) else $error("result moved alone");
  property p_rhold; o_rise_irq && !wr |=> o_rise_irq; endproperty
  a_rhold: assert property (p_rhold) else $error("rise flag lost");
  property p_fhold; o_fall_irq && !wr |=> o_fall_irq; endproperty
  a_fhold: assert property (p_fhold) else $error("fall flag lost");
  // A rise request appears only after a rising result or a write
  sequence s_up; $rose(o_compare_result); endsequence
  property p_rsrc; $rose(o_rise_irq) |-> $past(wr) ||
    ($past(o_compare_result) && !$past(o_compare_result, 2)); endproperty
  a_rsrc: assert property (p_rsrc) else $error("rise request uncaused");
  property p_phys; $changed(o_pos_hyst_sel) |-> $past(wr); endproperty
  a_phys: assert property (p_phys) else $error("pos hyst moved");
  property p_nhys; $changed(o_neg_hyst_sel) |-> $past(wr); endproperty
  a_nhys: assert property (p_nhys) else $error("neg hyst moved");
  property p_on; $changed(o_comparator_on) |-> $past(wr); endproperty
  a_on: assert property (p_on) else $error("enable moved");
  property p_rout; o_routed_result == (o_compare_result & o_comparator_on);
  endproperty
  a_rout: assert property (p_rout) else $error("routed not gated");
  property p_rst; $rose(i_rst_n) |-> o_pos_hyst_sel == 2'h0
    && o_neg_hyst_sel == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("hyst not cleared");
  c_up: cover property (s_up);
endmodule
bind comparator_ctrl_status_regs cmp_regs_checker chk (.i_clk, .i_rst_n,
  .i_psel, .i_penable, .i_pwrite, .i_plus_gt_minus, .o_comparator_on,
  .o_pos_hyst_sel, .o_neg_hyst_sel, .o_compare_result, .o_routed_result,
  .o_rise_irq, .o_fall_irq);

// ==== sim/comparator_ctrl_status_regs_test.sv ====
// Self-checking bench for the comparator register block
`timescale 1ns/1ps
`include "cmp_defs.vh"
module comparator_ctrl_status_regs_test;
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_psel = 1'h0, i_penable = 1'h0;
  logic i_pwrite = 1'h0, i_plus_gt_minus = 1'h0, i_counter_overflow = 1'h0;
  logic [31:0] i_paddr = 32'h0, i_pwdata = 32'h0;
  logic [3:0] i_pstrb = 4'hf;
  wire o_pready, o_pslverr, o_comparator_on, o_compare_result;
  wire o_routed_result, o_rise_irq, o_fall_irq;
  wire [31:0] o_prdata;
  wire [1:0] o_pos_hyst_sel, o_neg_hyst_sel, o_input_routing_sel;
  wire [1:0] o_response_mode_sel;
  localparam [11:0] ac = `CMP_ADDR_CTRL, am = `CMP_ADDR_MODE;
  localparam [11:0] ap = `CMP_ADDR_PAGE;
  int mismatches = 0, checks = 0, cyc = 0, k;
  logic [7:0] r;
  logic e;
  comparator_ctrl_status_regs uut (.i_clk, .i_rst_n, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_prdata,
    .o_pslverr, .i_plus_gt_minus, .i_counter_overflow, .o_comparator_on,
    .o_pos_hyst_sel, .o_neg_hyst_sel, .o_input_routing_sel,
    .o_response_mode_sel, .o_compare_result, .o_routed_result, .o_rise_irq,
    .o_fall_irq);
  // Clock at 100 MHz
  initial forever #5 i_clk = ~i_clk;
  // Cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      report_and_stop;
    end
  end
  // Compare one result and count it
  task automatic cmp(input [7:0] got, input [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer: setup, access until pready, then release
  task automatic bus(input w, input [11:0] a, input [7:0] d);
    @(posedge i_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= {20'h0, a};
    i_pwdata <= {24'h0, d};
    @(posedge i_clk);
    i_penable <= 1'h1;
    // pready high ends this wait; the bench timeout ends it only if pready never rises
    do begin
      @(posedge i_clk);
    end while (o_pready !== 1'h1);
    r = o_prdata[7:0];
    e = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic wr(input [11:0] a, input [7:0] d);
    bus(1'h1, a, d);
  endtask
  task automatic rd(input [11:0] a, input [7:0] x);
    bus(1'h0, a, 8'h0);
    cmp(r, x);
    cmp(e, 8'h0);
  endtask
  task automatic settle;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic inp(input v);
    @(posedge i_clk) i_plus_gt_minus <= v;
    settle;
  endtask
  task automatic ovf;
    @(posedge i_clk) i_counter_overflow <= 1'h1;
    @(posedge i_clk) i_counter_overflow <= 1'h0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'h1;
    rd(ac, 8'h00);
    rd(am, 8'h02);
    for (k = 0; k < 4; k++) begin
      wr(ac, {4'hf, k[1:0], k[1:0]});
      rd(ac, {4'h8, k[1:0], k[1:0]});
      cmp(o_pos_hyst_sel, k[1:0]);
      cmp(o_neg_hyst_sel, k[1:0]);
    end
    wr(ap, 8'h10);
    rd(ac, 8'h8f);
    wr(ap, 8'h05);
    bus(1'h0, ac, 8'h0);
    cmp(e, 8'h1);
    wr(ap, 8'h00);
    bus(1'h0, 12'h100, 8'h0);
    cmp(e, 8'h1);
    inp(1'h1);
    rd(ac, 8'hef);
    cmp(o_routed_result, 8'h1);
    wr(am, 8'h3d);
    rd(am, 8'h3d);
    cmp(o_input_routing_sel, 8'h3);
    cmp(o_response_mode_sel, 8'h1);
    cmp(o_rise_irq, 8'h1);
    cmp(o_fall_irq, 8'h0);
    wr(ac, 8'hcf);
    rd(ac, 8'hcf);
    cmp(o_rise_irq, 8'h0);
    inp(1'h0);
    rd(ac, 8'h9f);
    cmp(o_fall_irq, 8'h1);
    wr(am, 8'h72);
    settle;
    rd(ac, 8'hff);
    cmp(o_compare_result, 8'h1);
    ovf;
    rd(am, 8'hf2);
    inp(1'h1);
    ovf;
    rd(am, 8'h72);
    wr(ac, 8'h00);
    inp(1'h0);
    cmp(o_routed_result, 8'h0);
    cmp(o_comparator_on, 8'h0);
    wr(ac, 8'h0f);
    // Falling edge lands on the same edge as a flag clear; set wins
    fork
      inp(1'h1);
      wr(ac, 8'h0f);
    join
    rd(ac, 8'h1f);
    @(posedge i_clk);
    i_rst_n <= 1'h0;
    i_plus_gt_minus <= 1'h0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'h1;
    rd(ac, 8'h00);
    report_and_stop;
  end
endmodule
